// ### core/mcr_pkg.sv
// constants for the metering control register bank
// assumes a single 25 MHz clock and a plain register port
`default_nettype none
package mcr_pkg;
    localparam logic [7:0]  ADDR_CTRL_ZERO = 8'h02;
    localparam logic [7:0]  ADDR_CTRL_ONE  = 8'h03;
    localparam logic [7:0]  ADDR_CTRL_TWO  = 8'h04;
    localparam logic [7:0]  ADDR_STATUS    = 8'h05;
    localparam logic [31:0] RST_CTRL       = 32'h0000_0000;
    // writable masks; reserved bits read zero
    localparam logic [31:0] MASK_ZERO      = 32'h89FF_FFF7;
    localparam logic [31:0] MASK_ONE       = 32'h80FF_F7FF;
    localparam logic [31:0] MASK_TWO       = 32'hFFFF_FFFF;
    // ctrl zero fields
    localparam int B_DOUBLED  = 31;
    localparam int B_DC       = 27;
    localparam int B_APP      = 24;
    localparam int B_PAIR     = 20;
    localparam int B_QB       = 19;
    localparam int B_QA       = 18;
    localparam int B_BYP      = 13;
    localparam int B_SLOWRESP = 12;
    localparam int B_AVGRMS   = 10;
    localparam int B_AVGPWR   = 8;
    localparam int B_MODE     = 4;
    // ctrl one fields; B_IN4 is a ctrl two field
    localparam int B_COMPOFF  = 31;
    localparam int B_ECLK     = 23;
    localparam int B_SLOWACC  = 22;
    localparam int B_GAIN     = 21;
    localparam int B_ZCSRC    = 20;
    localparam int B_ZCEDGE   = 18;
    localparam int B_BAUD     = 17;
    localparam int B_UPLOAD   = 16;
    localparam int B_SLOWEN   = 15;
    localparam int B_P2       = 12;
    localparam int B_P1       = 8;
    localparam int B_ACC2     = 7;
    localparam int B_ACC1     = 6;
    localparam int B_WIDTH    = 4;
    localparam int B_SPEED    = 2;
    localparam int B_CREEP    = 1;
    localparam int B_FASTACC  = 0;
    localparam int B_IN4      = 30;
    // timing at 25 MHz
    localparam int CLK_HZ          = 25_000_000;
    localparam int SETTLE_NS       = 107_000;
    localparam int SETTLE_CYC      = SETTLE_NS / 40;
    localparam int CREEP_COUNT     = 3;
    localparam logic [3:0] PAIR_MAX = 4'h9;
    localparam logic [3:0] MODE_LOW_A = 4'h3;
    localparam logic [3:0] MODE_LOW_B = 4'h5;
    localparam logic [3:0] MODE_MAX   = 4'h9;
endpackage : mcr_pkg
`default_nettype wire

// ### core/mcr_regs.sv
// metering control register bank: three control words and a status word
// assumes one 25 MHz clock; register port with read data one cycle later
//
// Implementation choice: strobed register access.
`default_nettype none
module mcr_regs (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [31:0] reg_rdata,
    input  wire logic        avg_power_valid,
    input  wire logic        avg_power_below,
    output var  logic        dc_metering_enable,
    output var  logic        filter_gain_comp_off,
    output var  logic        apparent_source_sel,
    output var  logic [3:0]  fundamental_pair_sel,
    output var  logic        reactive_a_wave_sel,
    output var  logic        reactive_b_wave_sel,
    output var  logic [4:0]  highpass_bypass,
    output var  logic        slow_response,
    output var  logic [1:0]  avg_rms_refresh_sel,
    output var  logic [1:0]  avg_power_refresh_sel,
    output var  logic [3:0]  sample_rate_select,
    output var  logic        doubled_refresh,
    output var  logic        voltage_channel_en,
    output var  logic        current_b_channel_en,
    output var  logic        current_a_channel_en,
    output var  logic        energy_clk_sel,
    output var  logic        energy_clk_settling,
    output var  logic        slow_energy_acc,
    output var  logic        voltage_digital_gain,
    output var  logic        zero_cross_current_src,
    output var  logic [1:0]  zero_cross_edge,
    output var  logic        upload_baud_ctl,
    output var  logic        energy_upload_en,
    output var  logic        slow_energy_en,
    output var  logic        pulse_output_one_invert,
    output var  logic        pulse_output_one_enable,
    output var  logic        pulse_output_one_source,
    output var  logic        pulse_output_two_invert,
    output var  logic        pulse_output_two_enable,
    output var  logic        pulse_output_two_source,
    output var  logic        accumulator_one_en,
    output var  logic        accumulator_two_en,
    output var  logic [1:0]  pulse_width_sel,
    output var  logic [1:0]  pulse_speedup_sel,
    output var  logic        creep_detect_en,
    output var  logic        fast_accumulator_en,
    output var  logic        creep_status,
    output var  logic        acc_six_to_eight_run,
    output var  logic [1:0]  accumulator_four_input_mode,
    output var  logic [31:0] metering_control_two_out
);
    logic [31:0] metering_control_zero;
    logic [31:0] metering_control_one;
    logic [31:0] metering_control_two;
    logic [11:0] settle_cnt;
    logic [1:0]  below_cnt;
    logic [3:0]  next_pair;
    logic [3:0]  next_mode;
    logic [31:0] wdata_one;

    // write decode for the three control words
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            metering_control_zero <= mcr_pkg::RST_CTRL;
            metering_control_one  <= mcr_pkg::RST_CTRL;
            metering_control_two  <= mcr_pkg::RST_CTRL;
        end else if (reg_wr) begin
            case (reg_addr)
                mcr_pkg::ADDR_CTRL_ZERO: begin
                    metering_control_zero <= reg_wdata & mcr_pkg::MASK_ZERO;
                end
                mcr_pkg::ADDR_CTRL_ONE: begin
                    metering_control_one <= reg_wdata & mcr_pkg::MASK_ONE;
                end
                mcr_pkg::ADDR_CTRL_TWO: begin
                    metering_control_two <= reg_wdata & mcr_pkg::MASK_TWO;
                end
                default: begin
                end
            endcase
        end
    end

    assign wdata_one = metering_control_one;

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                mcr_pkg::ADDR_CTRL_ZERO: reg_rdata <= metering_control_zero;
                mcr_pkg::ADDR_CTRL_ONE:  reg_rdata <= metering_control_one;
                mcr_pkg::ADDR_CTRL_TWO:  reg_rdata <= metering_control_two;
                mcr_pkg::ADDR_STATUS: begin
                    reg_rdata <= {29'h0, energy_clk_settling,
                                  acc_six_to_eight_run, creep_status};
                end
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // out-of-range codes fold back to code 0
    always_comb begin
        next_pair = metering_control_zero[mcr_pkg::B_PAIR +: 4];
        if (next_pair > mcr_pkg::PAIR_MAX) begin
            next_pair = 4'h0;
        end
        next_mode = metering_control_zero[mcr_pkg::B_MODE +: 4];
        if (next_mode > mcr_pkg::MODE_MAX) begin
            next_mode = 4'h0;
        end else if (next_mode >= mcr_pkg::MODE_LOW_A &&
                     next_mode <= mcr_pkg::MODE_LOW_B) begin
            next_mode = 4'h0; // reserved codes
        end
    end

    // datapath controls from control word zero; compensation off also from word one
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dc_metering_enable    <= 1'b0;
            filter_gain_comp_off  <= 1'b0;
            apparent_source_sel   <= 1'b0;
            fundamental_pair_sel  <= 4'h0;
            reactive_a_wave_sel   <= 1'b0;
            reactive_b_wave_sel   <= 1'b0;
            highpass_bypass       <= 5'h00;
            slow_response         <= 1'b0;
            avg_rms_refresh_sel   <= 2'h0;
            avg_power_refresh_sel <= 2'h0;
            sample_rate_select    <= 4'h0;
            doubled_refresh       <= 1'b0;
            voltage_channel_en    <= 1'b0;
            current_b_channel_en  <= 1'b0;
            current_a_channel_en  <= 1'b0;
        end else begin
            dc_metering_enable   <= metering_control_zero[mcr_pkg::B_DC];
            filter_gain_comp_off <= wdata_one[mcr_pkg::B_COMPOFF] |
                metering_control_zero[mcr_pkg::B_DC];
            apparent_source_sel  <=
                metering_control_zero[mcr_pkg::B_APP];
            fundamental_pair_sel <= next_pair;
            reactive_a_wave_sel  <=
                metering_control_zero[mcr_pkg::B_QA];
            reactive_b_wave_sel  <=
                metering_control_zero[mcr_pkg::B_QB];
            highpass_bypass      <=
                metering_control_zero[mcr_pkg::B_BYP +: 5];
            slow_response        <=
                metering_control_zero[mcr_pkg::B_SLOWRESP];
            avg_rms_refresh_sel  <=
                metering_control_zero[mcr_pkg::B_AVGRMS +: 2];
            avg_power_refresh_sel <=
                metering_control_zero[mcr_pkg::B_AVGPWR +: 2];
            sample_rate_select   <= next_mode;
            doubled_refresh      <=
                metering_control_zero[mcr_pkg::B_DOUBLED];
            voltage_channel_en   <= metering_control_zero[2];
            current_b_channel_en <= metering_control_zero[1];
            current_a_channel_en <= metering_control_zero[0];
        end
    end

    // energy and pulse controls from control word one
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            energy_clk_sel          <= 1'b0;
            slow_energy_acc         <= 1'b0;
            voltage_digital_gain    <= 1'b0;
            zero_cross_current_src  <= 1'b0;
            zero_cross_edge         <= 2'h0;
            upload_baud_ctl         <= 1'b0;
            energy_upload_en        <= 1'b0;
            slow_energy_en          <= 1'b0;
            pulse_output_one_invert <= 1'b0;
            pulse_output_one_enable <= 1'b0;
            pulse_output_one_source <= 1'b0;
            pulse_output_two_invert <= 1'b0;
            pulse_output_two_enable <= 1'b0;
            pulse_output_two_source <= 1'b0;
            accumulator_one_en      <= 1'b0;
            accumulator_two_en      <= 1'b0;
            pulse_width_sel         <= 2'h0;
            pulse_speedup_sel       <= 2'h0;
            creep_detect_en         <= 1'b0;
            fast_accumulator_en     <= 1'b0;
            acc_six_to_eight_run    <= 1'b0;
        end else begin
            energy_clk_sel <= wdata_one[mcr_pkg::B_ECLK];
            slow_energy_acc <= wdata_one[mcr_pkg::B_SLOWACC];
            acc_six_to_eight_run <=
                !wdata_one[mcr_pkg::B_SLOWACC];
            voltage_digital_gain <= wdata_one[mcr_pkg::B_GAIN];
            zero_cross_current_src <= wdata_one[mcr_pkg::B_ZCSRC];
            zero_cross_edge <= wdata_one[mcr_pkg::B_ZCEDGE +: 2];
            upload_baud_ctl <= wdata_one[mcr_pkg::B_BAUD];
            energy_upload_en <= wdata_one[mcr_pkg::B_UPLOAD];
            slow_energy_en <= wdata_one[mcr_pkg::B_SLOWEN];
            pulse_output_one_invert <=
                wdata_one[mcr_pkg::B_P1 + 2];
            pulse_output_one_enable <=
                wdata_one[mcr_pkg::B_P1 + 1];
            pulse_output_one_source <=
                wdata_one[mcr_pkg::B_P1];
            pulse_output_two_invert <=
                wdata_one[mcr_pkg::B_P2 + 2];
            pulse_output_two_enable <=
                wdata_one[mcr_pkg::B_P2 + 1];
            pulse_output_two_source <=
                wdata_one[mcr_pkg::B_P2];
            accumulator_two_en <= wdata_one[mcr_pkg::B_ACC2];
            accumulator_one_en <= wdata_one[mcr_pkg::B_ACC1];
            pulse_width_sel <= wdata_one[mcr_pkg::B_WIDTH +: 2];
            pulse_speedup_sel <= wdata_one[mcr_pkg::B_SPEED +: 2];
            creep_detect_en <= wdata_one[mcr_pkg::B_CREEP];
            fast_accumulator_en <= wdata_one[mcr_pkg::B_FASTACC];
        end
    end

    // settle window after an energy clock switch
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt          <= 12'h000;
            energy_clk_settling <= 1'b0;
        end else if (wdata_one[mcr_pkg::B_ECLK] != energy_clk_sel) begin
            settle_cnt          <= 12'(mcr_pkg::SETTLE_CYC);
            energy_clk_settling <= 1'b1;
        end else if (settle_cnt != 12'h000) begin
            settle_cnt          <= settle_cnt - 12'h001;
            energy_clk_settling <= (settle_cnt != 12'h001);
        end
    end

    // creep: three consecutive low averages set the status
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            below_cnt    <= 2'h0;
            creep_status <= 1'b0;
        end else if (!wdata_one[mcr_pkg::B_CREEP]) begin
            below_cnt    <= 2'h0;
            creep_status <= 1'b0;
        end else if (avg_power_valid) begin
            if (!avg_power_below) begin
                below_cnt    <= 2'h0;
                creep_status <= 1'b0;
            end else if (below_cnt == 2'(mcr_pkg::CREEP_COUNT - 1)) begin
                creep_status <= 1'b1;
            end else begin
                below_cnt <= below_cnt + 2'h1;
            end
        end
    end

    // control word two: accumulator four mode and raw word
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            accumulator_four_input_mode <= 2'h0;
            metering_control_two_out    <= 32'h0000_0000;
        end else begin
            accumulator_four_input_mode <=
                metering_control_two[mcr_pkg::B_IN4 +: 2];
            metering_control_two_out    <= metering_control_two;
        end
    end
endmodule : mcr_regs
`default_nettype wire

// ### sim/mcr_regs_assertions.sv
// checker for the metering control register bank, bound to its ports
// assumes one clock mclk and asynchronous active low reset rst_n
`default_nettype none
module mcr_regs_assertions (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        avg_power_valid,
    input wire logic        avg_power_below,
    input wire logic        dc_metering_enable,
    input wire logic        filter_gain_comp_off,
    input wire logic [3:0]  fundamental_pair_sel,
    input wire logic [3:0]  sample_rate_select,
    input wire logic        energy_clk_sel,
    input wire logic        energy_clk_settling,
    input wire logic        slow_energy_acc,
    input wire logic        acc_six_to_eight_run,
    input wire logic        creep_detect_en,
    input wire logic        creep_status,
    input wire logic [31:0] metering_control_two_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE_LAST = mcr_pkg::SETTLE_CYC - 1;
    logic [1:0]  below_cnt;
    logic [11:0] settle_cnt;
    logic        sel_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // consecutive below-threshold averages, capped at three
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) below_cnt <= 2'h0;
        else if (!creep_detect_en || (avg_power_valid && !avg_power_below))
            below_cnt <= 2'h0;
        else if (avg_power_valid && below_cnt != 2'h3)
            below_cnt <= below_cnt + 2'h1;
    end
    // length of the settling window since the last clock switch
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt <= 12'h000;
            sel_q      <= 1'b0;
        end else begin
            sel_q <= energy_clk_sel;
            if (!energy_clk_settling || energy_clk_sel != sel_q) begin
                settle_cnt <= 12'h000;
            end else if (settle_cnt != 12'hFFF) begin
                settle_cnt <= settle_cnt + 12'h001;
            end
        end
    end
    AST_DC_COMP_OFF: assert property (
        dc_metering_enable |-> filter_gain_comp_off)
        else $error("filter gain compensation on in dc mode");
    AST_PAIR_RANGE: assert property (
        fundamental_pair_sel <= 4'h9)
        else $error("fundamental pair code above nine");
    AST_MODE_RANGE: assert property (
        sample_rate_select <= 4'h9 &&
        !(sample_rate_select inside {[4'h3:4'h5]}))
        else $error("reserved sample mode passed through");
    AST_ACC_STOP: assert property (
        slow_energy_acc |-> !acc_six_to_eight_run)
        else $error("accumulators six to eight run in slow mode");
    AST_CREEP_SET: assert property (
        $rose(creep_status) |-> below_cnt == 2'h3)
        else $error("creep status without three low averages");
    AST_CREEP_OFF: assert property (
        (!creep_detect_en)[*2] |-> !creep_status)
        else $error("creep status while detection disabled");
    AST_SETTLE_START: assert property (
        $changed(energy_clk_sel) |-> ##[0:2] energy_clk_settling)
        else $error("no settling after energy clock switch");
    AST_SETTLE_HOLD: assert property (
        $rose(energy_clk_settling) |=> energy_clk_settling[*8])
        else $error("settling window too short");
    AST_SETTLE_MAX: assert property (
        settle_cnt <= SETTLE_LAST)
        else $error("settling window too long");
    AST_SETTLE_LEN: assert property (
        $fell(energy_clk_settling) |-> settle_cnt == SETTLE_LAST)
        else $error("settling window length wrong");
    AST_RDATA_IDLE: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside its cycle");
    AST_RD_UNMAPPED: assert property (
        reg_rd && (reg_addr < 8'h02 || reg_addr > 8'h05)
        |=> reg_rdata == 32'h0)
        else $error("unmapped read returned data");
    AST_CTRL2_HOLD: assert property (
        (!reg_wr)[*2] |=> $stable(metering_control_two_out))
        else $error("control word two changed without a write");
endmodule : mcr_regs_assertions
`default_nettype wire

// ### sim/tb_metering_control_regs.sv
// self-checking bench for the metering control register bank
// assumes mcr_pkg and mcr_regs compiled first; drives the register port
`default_nettype none
module tb_metering_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst_n, reg_wr, reg_rd, avg_power_valid, avg_power_below;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, metering_control_two_out;
    logic        dc_metering_enable, filter_gain_comp_off, apparent_source_sel;
    logic        reactive_a_wave_sel, reactive_b_wave_sel, slow_response;
    logic        doubled_refresh, voltage_channel_en, current_b_channel_en;
    logic        current_a_channel_en, energy_clk_sel, energy_clk_settling;
    logic        slow_energy_acc, voltage_digital_gain, zero_cross_current_src;
    logic        upload_baud_ctl, energy_upload_en, slow_energy_en;
    logic        pulse_output_one_invert, pulse_output_one_enable;
    logic        pulse_output_one_source, pulse_output_two_invert;
    logic        pulse_output_two_enable, pulse_output_two_source;
    logic        accumulator_one_en, accumulator_two_en, creep_detect_en;
    logic        fast_accumulator_en, creep_status, acc_six_to_eight_run;
    logic [3:0]  fundamental_pair_sel, sample_rate_select;
    logic [4:0]  highpass_bypass;
    logic [1:0]  avg_rms_refresh_sel, avg_power_refresh_sel, zero_cross_edge;
    logic [1:0]  pulse_width_sel, pulse_speedup_sel;
    logic [1:0]  accumulator_four_input_mode;
    int          failures, n_compared, cnt;
    logic [31:0] c0, c1, c2, d, seed_ret;
    logic [9:0]  pat;
    mcr_regs i_dut (.*);
    // free running 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input string name, input logic [63:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic pulse(input logic b);
        @(posedge mclk);
        avg_power_valid <= 1'b1; avg_power_below <= b;
        @(posedge mclk);
        avg_power_valid <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : pulse
    // expected control zero outputs, reserved codes folded to zero
    function automatic logic [26:0] exp0(input logic [31:0] a, b);
        logic [3:0] p, m;
        p = (a[23:20] > 4'h9) ? 4'h0 : a[23:20];
        m = (a[7:4] > 4'h9 || a[7:4] inside {[4'h3:4'h5]}) ? 4'h0 : a[7:4];
        return {a[27], b[31] | a[27], a[24], p, a[19:8], m, a[31], a[2:0]};
    endfunction : exp0
    // watchdog against a hung run
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        $display("watchdog expired");
        stop_test();
    end
    // main sequence
    initial begin
        rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
        reg_wdata = 32'h0; avg_power_valid = 1'b0; avg_power_below = 1'b0;
        failures = 0; n_compared = 0;
        seed_ret = $urandom(32'hFD53163E);
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        rd(8'h02, d); chk("ctrl0 reset", d, 0);
        rd(8'h03, d); chk("ctrl1 reset", d, 0);
        rd(8'h04, d); chk("ctrl2 reset", d, 0);
        $display("test reset done");
        for (int k = 0; k < 16; k++) begin
            c0 = $urandom; c1 = $urandom; c2 = $urandom;
            c0[23:20] = k[3:0]; c0[7:4] = k[3:0];
            if (k == 0) begin
                c0[27] = 1'b1; c1[31] = 1'b0;
            end
            wr(8'h02, c0); wr(8'h03, c1); wr(8'h04, c2);
            repeat (2) @(posedge mclk);
            #1;
            chk("ctrl0 fields", 64'({dc_metering_enable, filter_gain_comp_off,
                apparent_source_sel, fundamental_pair_sel, reactive_b_wave_sel,
                reactive_a_wave_sel, highpass_bypass, slow_response,
                avg_rms_refresh_sel, avg_power_refresh_sel, sample_rate_select,
                doubled_refresh, voltage_channel_en, current_b_channel_en,
                current_a_channel_en}), 64'(exp0(c0, c1)));
            chk("ctrl1 fields", 64'({energy_clk_sel, slow_energy_acc,
                voltage_digital_gain, zero_cross_current_src, zero_cross_edge,
                upload_baud_ctl, energy_upload_en, slow_energy_en,
                pulse_output_two_invert, pulse_output_two_enable,
                pulse_output_two_source, pulse_output_one_invert,
                pulse_output_one_enable, pulse_output_one_source,
                accumulator_two_en, accumulator_one_en, pulse_width_sel,
                pulse_speedup_sel, creep_detect_en, fast_accumulator_en,
                acc_six_to_eight_run}), 64'({c1[23:12], c1[10:0], ~c1[22]}));
            chk("ctrl2 fields", 64'({accumulator_four_input_mode,
                metering_control_two_out}), 64'({c2[31:30], c2}));
            rd(8'h02, d); chk("ctrl0 read", d, c0 & mcr_pkg::MASK_ZERO);
            rd(8'h03, d); chk("ctrl1 read", d, c1 & mcr_pkg::MASK_ONE);
            rd(8'h04, d); chk("ctrl2 read", d, c2 & mcr_pkg::MASK_TWO);
        end
        $display("test fields done");
        wr(8'h03, 32'h0000_0002);
        pat = 10'b1110111011;
        cnt = 0;
        for (int i = 0; i < 10; i++) begin
            pulse(pat[i]);
            cnt = pat[i] ? cnt + 1 : 0;
            chk("creep status", creep_status, cnt >= 3);
        end
        rd(8'h05, d); chk("status creep", d[0], cnt >= 3);
        wr(8'h03, 32'h0000_0000);
        repeat (3) @(posedge mclk);
        #1 chk("creep disabled", creep_status, 0);
        $display("test creep done");
        // switch the energy clock with both pulse outputs disabled
        wr(8'h03, 32'h0080_0000);
        repeat (10) @(posedge mclk);
        #1 chk("settling on", energy_clk_settling, 1);
        rd(8'h05, d); chk("status settle", d[2], 1);
        repeat (mcr_pkg::SETTLE_CYC - 12) @(posedge mclk);
        #1 chk("settling end", energy_clk_settling, 1);
        @(posedge mclk);
        #1 chk("settling off", energy_clk_settling, 0);
        $display("test settle done");
        c0 = $urandom;
        wr(8'h02, c0);
        wr(8'h10, $urandom); rd(8'h10, d); chk("unmapped read", d, 0);
        wr(8'h05, 32'hFFFF_FFFF); rd(8'h05, d);
        chk("status word", d, 32'h0000_0002);
        rd(8'h02, d); chk("ctrl0 kept", d, c0 & mcr_pkg::MASK_ZERO);
        $display("test unmapped done");
        // reset again in mid-run; every control word returns to zero
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1 chk("dc after reset", dc_metering_enable, 0);
        rd(8'h02, d); chk("ctrl0 after reset", d, 0);
        rd(8'h03, d); chk("ctrl1 after reset", d, 0);
        $display("test reset again done");
        stop_test();
    end
endmodule : tb_metering_control_regs
bind mcr_regs mcr_regs_assertions i_chk (.*);
`default_nettype wire
